// [fpr_pkg.sv]
// Purpose: Shared constants and types for the flash protect and function register block.
// Assumes: Single clock mclk, registers reached through the documented command strobes.
// Notes: Field positions follow the function register layout, top bit down.
package fpr_pkg;
    localparam int FUNC_W = 8;
    localparam int PCODE_W = 4;
    localparam int BLK_W = 6;
    localparam int ADDR_W = 22;
    localparam int ADDR_BLK_HI = 21;
    localparam int ADDR_BLK_LO = 16;
    localparam int RP_W = 8;
    localparam int FR_LOCK_HI = 7;
    localparam int FR_LOCK_LO = 4;
    localparam int FR_ERASE_SUSPENDED_FLAG = 3;
    localparam int FR_PROGRAM_SUSPENDED_FLAG = 2;
    localparam int FR_RSVD = 1;
    localparam int FR_RSTDIS = 0;
    localparam logic [7:0] RP_NV_RESET = 8'h00;
    localparam logic [7:0] ERP_NV_RESET = 8'h00;
    localparam logic [3:0] PCODE_NONE_LO = 4'h0;
    localparam logic [3:0] PCODE_NONE_HI = 4'hf;
    localparam logic [3:0] PCODE_ALL_LO = 4'h7;
    localparam logic [3:0] PCODE_ALL_HI = 4'h8;
    localparam logic [5:0] BLK_LAST = 6'h3f;
    localparam logic [2:0] PUP_LOAD_CYCLES = 3'h2;

    typedef enum logic [1:0] {
        FPR_PUP_IDLE = 2'b00,
        FPR_PUP_LOAD = 2'b01,
        FPR_PUP_DONE = 2'b11
    } fpr_pup_type;
endpackage

// [fpr_prot_if.sv]
// Purpose: Carries the protect code and block index to the range decoder.
// Assumes: Combinational decoder on the far side.
// Notes: None.
interface fpr_prot_if;
    logic [3:0] pcode;
    logic [5:0] blk;
    logic hit;
    modport ctrl (output pcode, output blk, input hit);
    modport dec (input pcode, input blk, output hit);
endinterface

// [fpr_range_dec.sv]
// Purpose: Decodes a block-protect code and tests one 64-Kbyte block against it.
// Assumes: Codes 1 to 6 count from the top block, 9 to 14 from block 0.
// Notes: Purely combinational.
module fpr_range_dec (
    fpr_prot_if.dec p // Code, block index and hit result.
);
    wire [2:0] top_n;
    wire [2:0] bot_n;
    wire [5:0] top_mask;
    wire [5:0] bot_mask;
    wire is_none;
    wire is_all;
    wire is_top;
    wire top_hit;
    wire bot_hit;

    // Top range of 2^(code-1) blocks: the upper bits of the index must all be one.
    assign top_n = 3'(p.pcode[2:0] - 3'h1);
    assign top_mask = 6'(6'h3f << top_n);
    assign top_hit = (p.blk & top_mask) == top_mask;
    // Bottom range of 2^(14-code) blocks: the upper bits of the index must all be zero.
    assign bot_n = 3'(4'he - p.pcode);
    assign bot_mask = 6'(6'h3f << bot_n);
    assign bot_hit = (p.blk & bot_mask) == 6'h00;
    assign is_none = (p.pcode == fpr_pkg::PCODE_NONE_LO) || (p.pcode == fpr_pkg::PCODE_NONE_HI);
    assign is_all = (p.pcode == fpr_pkg::PCODE_ALL_LO) || (p.pcode == fpr_pkg::PCODE_ALL_HI);
    assign is_top = ~p.pcode[3];
    assign p.hit = is_none ? 1'b0 : is_all ? 1'b1 : is_top ? top_hit : bot_hit;
endmodule

// [fpr_regs.sv]
// Purpose: Protection check, function register and read-parameter registers of a serial flash.
// Assumes: The command decoder delivers one-cycle strobes synchronous to mclk.
// Notes: Non-volatile cells are modelled as flops reset to their shipped values.

//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Codes 0/15 protect none, 1-6 top blocks, 7/8 all, 9-14 bottom blocks.
// - Function register: locks 3..0, erase-suspended, program-suspended, reserved, reset-disable.
// - Reset-disable bit writable while 0, read-only once 1, default per variant.
// - With reset-disable set, reset comes from the shared hold-or-reset pin.
// - One-time bits written to 1 never return to 0.
// - Program-suspended flag sets when suspend accepted during program.
// - Program-suspended flag clears when program resumes.
// - Erase-suspended flag sets when suspend accepted during erase.
// - Erase-suspended flag clears when erase resumes.
// - Four row lock bits, default 0; a locked row refuses programming.
// - Read and extended read parameters each have non-volatile and volatile copies.
// - At power-up each volatile copy loads from its non-volatile copy.
// - Program or erase inside the protected range is inhibited.
// - Whole-array erase ignored unless all protect bits are zero.
module fpr_regs #(
    parameter logic RSTDIS_DEFAULT = 1'b0 // Variant default of the reset-disable bit.
) (
    input wire logic mclk, // Clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [3:0] protect_code, // Block-protect code from the status register.
    input wire logic op_req, // One-cycle request to program or erase.
    input wire logic op_is_erase, // Request is an erase.
    input wire logic whole_array_erase, // Request is a whole-array erase.
    input wire logic op_info_row, // Request targets an information row.
    input wire logic [1:0] op_row, // Information row index.
    input wire logic [21:0] op_addr, // Byte address of the request.
    input wire logic func_wr, // Write strobe for the function register.
    input wire logic [7:0] func_wdata, // Function register write data.
    input wire logic prog_busy, // A program operation is running.
    input wire logic erase_busy, // An erase operation is running.
    input wire logic suspend_cmd, // Suspend command accepted.
    input wire logic resume_cmd, // Resume command accepted.
    input wire logic rp_nv_wr, // Write non-volatile read parameters.
    input wire logic rp_v_wr, // Write volatile read parameters.
    input wire logic erp_nv_wr, // Write non-volatile extended read parameters.
    input wire logic erp_v_wr, // Write volatile extended read parameters.
    input wire logic [7:0] param_wdata, // Parameter write data.
    input wire logic ded_reset_n, // Dedicated reset pin, active low.
    input wire logic hold_reset_n, // Shared hold-or-reset pin, active low.
    output logic op_grant, // Request allowed, one-cycle pulse.
    output logic op_refuse, // Request refused, one-cycle pulse.
    output logic [7:0] func_rdata, // Function register value.
    output logic [7:0] rp_nv, // Non-volatile read parameters.
    output logic [7:0] rp_v, // Volatile read parameters.
    output logic [7:0] erp_nv, // Non-volatile extended read parameters.
    output logic [7:0] erp_v, // Volatile extended read parameters.
    output logic pup_done, // Power-up load finished.
    output logic pin_reset_n // Selected device reset request, active low.
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [3:0] lock_q;
    logic erase_suspended_flag_q;
    logic program_suspended_flag_q;
    logic rstdis_q;
    logic rstdis_init_q;
    logic grant_q;
    logic refuse_q;
    logic [7:0] rp_nv_q;
    logic [7:0] rp_v_q;
    logic [7:0] erp_nv_q;
    logic [7:0] erp_v_q;
    logic pin_q;
    logic [2:0] pup_cnt_q;
    logic pup_done_q;
    fpr_pkg::fpr_pup_type pup_q;
    fpr_pkg::fpr_pup_type pup_d;
    fpr_prot_if prot ();

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Protection decision.
    wire row_locked;
    wire prot_hit;
    wire wae_blocked;
    wire refuse_now;

    assign prot.pcode = protect_code;
    assign prot.blk = op_addr[fpr_pkg::ADDR_BLK_HI:fpr_pkg::ADDR_BLK_LO];
    fpr_range_dec u_dec (
        .p (prot.dec)
    );
    assign prot_hit = prot.hit && !op_info_row;
    assign row_locked = op_info_row && !op_is_erase && lock_q[op_row];
    assign wae_blocked = whole_array_erase && (protect_code != 4'h0);
    assign refuse_now = row_locked || wae_blocked || (prot_hit && !whole_array_erase);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            grant_q <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            grant_q <= op_req && !refuse_now;
            refuse_q <= op_req && refuse_now;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Function register. One-time bits only ever OR in new ones.
    wire [3:0] lock_d;
    wire rstdis_d;
    wire program_suspended_flag_set;
    wire erase_suspended_flag_set;

    assign lock_d = lock_q | (func_wr ? func_wdata[fpr_pkg::FR_LOCK_HI:fpr_pkg::FR_LOCK_LO]
                                      : 4'h0);
    assign rstdis_d = rstdis_q | (func_wr && func_wdata[fpr_pkg::FR_RSTDIS]);
    assign program_suspended_flag_set = suspend_cmd && prog_busy;
    assign erase_suspended_flag_set = suspend_cmd && erase_busy;

    // The variant default is caught on the first clock after release, not under reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 4'h0;
            rstdis_q <= 1'b0;
            rstdis_init_q <= 1'b0;
            program_suspended_flag_q <= 1'b0;
            erase_suspended_flag_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
            rstdis_init_q <= 1'b1;
            rstdis_q <= rstdis_init_q ? rstdis_d : RSTDIS_DEFAULT;
            program_suspended_flag_q <= program_suspended_flag_set | (program_suspended_flag_q & ~resume_cmd);
            erase_suspended_flag_q <= erase_suspended_flag_set | (erase_suspended_flag_q & ~resume_cmd);
        end
    end

    assign func_rdata = {lock_q, erase_suspended_flag_q, program_suspended_flag_q, 1'b0, rstdis_q};

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Reset pin selection.
    wire pin_sel_n;
    assign pin_sel_n = rstdis_q ? hold_reset_n : ded_reset_n;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= pin_sel_n;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Read parameters and power-up load.
    wire pup_load;
    assign pup_load = (pup_q == fpr_pkg::FPR_PUP_LOAD);

    always_comb begin
        pup_d = pup_q;
        case (pup_q)
            fpr_pkg::FPR_PUP_IDLE: pup_d = fpr_pkg::FPR_PUP_LOAD;
            fpr_pkg::FPR_PUP_LOAD: begin
                if (pup_cnt_q == fpr_pkg::PUP_LOAD_CYCLES) begin
                    pup_d = fpr_pkg::FPR_PUP_DONE;
                end
            end
            fpr_pkg::FPR_PUP_DONE: pup_d = fpr_pkg::FPR_PUP_DONE;
            default: pup_d = fpr_pkg::FPR_PUP_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pup_q <= fpr_pkg::FPR_PUP_IDLE;
            pup_cnt_q <= 3'h0;
            pup_done_q <= 1'b0;
        end else begin
            pup_q <= pup_d;
            pup_cnt_q <= pup_load ? 3'(pup_cnt_q + 3'h1) : 3'h0;
            // Registered beside the state so the done level leaves the block from a flop.
            pup_done_q <= (pup_d == fpr_pkg::FPR_PUP_DONE);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rp_nv_q <= fpr_pkg::RP_NV_RESET;
            erp_nv_q <= fpr_pkg::ERP_NV_RESET;
        end else begin
            if (rp_nv_wr) begin
                rp_nv_q <= param_wdata;
            end
            if (erp_nv_wr) begin
                erp_nv_q <= param_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rp_v_q <= 8'h00;
            erp_v_q <= 8'h00;
        end else if (pup_load) begin
            rp_v_q <= rp_nv_q;
            erp_v_q <= erp_nv_q;
        end else begin
            if (rp_v_wr) begin
                rp_v_q <= param_wdata;
            end
            if (erp_v_wr) begin
                erp_v_q <= param_wdata;
            end
        end
    end

    assign op_grant = grant_q;
    assign op_refuse = refuse_q;
    assign rp_nv = rp_nv_q;
    assign rp_v = rp_v_q;
    assign erp_nv = erp_nv_q;
    assign erp_v = erp_v_q;
    assign pup_done = pup_done_q;
    assign pin_reset_n = pin_q;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_lock_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (lock_q != 4'h0) |=> ((lock_q & $past(lock_q)) == $past(lock_q)))
        else $error("row lock bit returned to zero");
    a_rstdis_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        (rstdis_init_q && rstdis_q) |=> rstdis_q)
        else $error("reset disable bit cleared");
    a_program_suspended_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (suspend_cmd && prog_busy) |=> program_suspended_flag_q)
        else $error("program suspended flag not set");
    a_program_suspended_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (resume_cmd && !(suspend_cmd && prog_busy)) |=> !program_suspended_flag_q)
        else $error("program suspended flag not cleared");
    a_erase_suspended_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (suspend_cmd && erase_busy) |=> erase_suspended_flag_q)
        else $error("erase suspended flag not set");
    a_erase_suspended_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (resume_cmd && !(suspend_cmd && erase_busy)) |=> !erase_suspended_flag_q)
        else $error("erase suspended flag not cleared");
    a_locked_row: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && op_info_row && !op_is_erase && lock_q[op_row]) |=> (op_refuse && !op_grant))
        else $error("program to locked row granted");
    a_wae_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && whole_array_erase && protect_code != 4'h0) |=> op_refuse)
        else $error("whole array erase not refused");
    a_range_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && protect_code inside {4'h7, 4'h8}) |=> op_refuse)
        else $error("protected range not refused");
    a_none_pass: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && protect_code == 4'h0) |=> op_grant)
        else $error("unprotected request refused");
    a_pup_load: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(pup_done) |-> (rp_v == rp_nv && erp_v == erp_nv))
        else $error("volatile copy not loaded at power up");
    a_pin_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        (rstdis_q && !hold_reset_n) |=> !pin_reset_n)
        else $error("shared reset pin ignored");
    a_answer_single: assert property (@(posedge mclk) disable iff (!rst_n)
        op_req |=> (op_grant != op_refuse))
        else $error("request not answered exactly once");
    a_answer_unasked: assert property (@(posedge mclk) disable iff (!rst_n)
        !op_req |=> (!op_grant && !op_refuse))
        else $error("answer without a request");
    // Fixed code points of the decode table, checked apart from the decoder's mask arithmetic.
    a_top_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && !whole_array_erase && protect_code == 4'h1
            && op_addr[fpr_pkg::ADDR_BLK_HI:fpr_pkg::ADDR_BLK_LO] == 6'h3f) |=> op_refuse)
        else $error("top block not protected");
    a_top_below: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && !whole_array_erase && protect_code == 4'h1
            && op_addr[fpr_pkg::ADDR_BLK_HI:fpr_pkg::ADDR_BLK_LO] == 6'h3e) |=> op_grant)
        else $error("block below top range refused");
    a_bottom_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && !whole_array_erase && protect_code == 4'he
            && op_addr[fpr_pkg::ADDR_BLK_HI:fpr_pkg::ADDR_BLK_LO] == 6'h00) |=> op_refuse)
        else $error("bottom block not protected");
    a_bottom_above: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && !op_info_row && !whole_array_erase && protect_code == 4'h9
            && op_addr[fpr_pkg::ADDR_BLK_HI:fpr_pkg::ADDR_BLK_LO] == 6'h20) |=> op_grant)
        else $error("block above bottom range refused");
    a_info_bypass: assert property (@(posedge mclk) disable iff (!rst_n)
        (op_req && op_info_row && !whole_array_erase && (op_is_erase || !lock_q[op_row]))
            |=> op_grant)
        else $error("open information row refused");
    a_pin_dedicated: assert property (@(posedge mclk) disable iff (!rst_n)
        (!rstdis_q && !ded_reset_n) |=> !pin_reset_n)
        else $error("dedicated reset pin ignored");
    a_ded_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (rstdis_q && hold_reset_n) |=> pin_reset_n)
        else $error("disabled dedicated reset pin still used");
    a_volatile_load: assert property (@(posedge mclk) disable iff (!rst_n)
        pup_load |=> (rp_v == $past(rp_nv) && erp_v == $past(erp_nv)))
        else $error("volatile copy not loaded from non-volatile copy");
    a_flags_readonly: assert property (@(posedge mclk) disable iff (!rst_n)
        (func_wr && !suspend_cmd && !resume_cmd) |=> $stable({erase_suspended_flag_q, program_suspended_flag_q}))
        else $error("suspend flags changed by a register write");
endmodule

// [fpr_host_model.sv]
// Purpose: Host-side model that issues program and erase requests to the protect logic.
// Assumes: Requests launch at a falling edge and are answered one cycle after being taken.
// Notes: Released qualifiers carry inverted values so stale data is never mistaken for valid.
module fpr_host_model (
    input wire logic mclk, // Clock.
    input wire logic op_grant, // Grant answer.
    input wire logic op_refuse, // Refuse answer.
    output logic op_req, // Request strobe.
    output logic op_is_erase, // Erase qualifier.
    output logic whole_array_erase, // Whole-array qualifier.
    output logic op_info_row, // Information-row qualifier.
    output logic [1:0] op_row, // Row index.
    output logic [21:0] op_addr // Byte address.
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        op_req = 1'b0;
        op_is_erase = 1'b0;
        whole_array_erase = 1'b0;
        op_info_row = 1'b0;
        op_row = 2'h0;
        op_addr = 22'h000000;
    end

    task automatic request(input logic er, input logic wae, input logic info,
                           input logic [1:0] row, input logic [21:0] addr,
                           output logic g, output logic r);
        @(negedge mclk);
        op_req = 1'b1;
        op_is_erase = er;
        whole_array_erase = wae;
        op_info_row = info;
        op_row = row;
        op_addr = addr;
        @(negedge mclk);
        g = op_grant;
        r = op_refuse;
        op_req = 1'b0;
        op_is_erase = ~er;
        whole_array_erase = ~wae;
        op_info_row = ~info;
        op_row = ~row;
        op_addr = ~addr;
    endtask
endmodule

// [flash_protect_and_function_regs_tb.sv]
// Purpose: Self-checking bench for the protect and function register block.
// Assumes: Inputs change at the falling edge; results are sampled one falling edge later.
// Notes: Non-volatile cells reset to shipped values, so power-up load is seen from reset.
module flash_protect_and_function_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, resetn, func_wr, prog_busy, erase_busy, suspend_cmd, resume_cmd;
    logic rp_nv_wr, rp_v_wr, erp_nv_wr, erp_v_wr, ded_reset_n, hold_reset_n;
    logic op_req, op_is_erase, whole_array_erase, op_info_row, op_grant, op_refuse;
    logic pup_done, pin_reset_n;
    logic [1:0] op_row;
    logic [3:0] protect_code;
    logic [21:0] op_addr;
    logic [7:0] func_wdata, param_wdata, func_rdata, rp_nv, rp_v, erp_nv, erp_v;
    int num_errors = 0;
    int num_checks = 0;

    fpr_regs u_fpr_regs (.mclk(mclk), .resetn(resetn), .protect_code(protect_code),
        .op_req(op_req), .op_is_erase(op_is_erase), .whole_array_erase(whole_array_erase),
        .op_info_row(op_info_row), .op_row(op_row), .op_addr(op_addr), .func_wr(func_wr),
        .func_wdata(func_wdata), .prog_busy(prog_busy), .erase_busy(erase_busy),
        .suspend_cmd(suspend_cmd), .resume_cmd(resume_cmd), .rp_nv_wr(rp_nv_wr),
        .rp_v_wr(rp_v_wr), .erp_nv_wr(erp_nv_wr), .erp_v_wr(erp_v_wr),
        .param_wdata(param_wdata), .ded_reset_n(ded_reset_n), .hold_reset_n(hold_reset_n),
        .op_grant(op_grant), .op_refuse(op_refuse), .func_rdata(func_rdata), .rp_nv(rp_nv),
        .rp_v(rp_v), .erp_nv(erp_nv), .erp_v(erp_v), .pup_done(pup_done),
        .pin_reset_n(pin_reset_n));

    fpr_host_model u_fpr_host_model (.mclk(mclk), .op_grant(op_grant), .op_refuse(op_refuse),
        .op_req(op_req), .op_is_erase(op_is_erase), .whole_array_erase(whole_array_erase),
        .op_info_row(op_info_row), .op_row(op_row), .op_addr(op_addr));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic prot_exp(input logic [3:0] c, input logic [5:0] b);
        if (c == 4'h7 || c == 4'h8) return 1'b1;
        if (c >= 4'h1 && c <= 4'h6) return int'(b) >= 64 - (1 << (int'(c) - 1));
        if (c >= 4'h9 && c <= 4'he) return int'(b) < (1 << (14 - int'(c)));
        return 1'b0;
    endfunction

    task automatic req_chk(input logic er, input logic wae, input logic info,
                           input logic [1:0] row, input logic [21:0] addr, input logic ok);
        logic g;
        logic r;
        u_fpr_host_model.request(er, wae, info, row, addr, g, r);
        check({7'h00, g}, {7'h00, ok}, "grant");
        check({7'h00, r}, {7'h00, ~ok}, "refuse");
    endtask

    task automatic fwrite(input logic [7:0] d);
        @(negedge mclk);
        func_wr = 1'b1;
        func_wdata = d;
        @(negedge mclk);
        func_wr = 1'b0;
        func_wdata = ~d;
    endtask

    task automatic cmd(input logic sus);
        @(negedge mclk);
        suspend_cmd = sus;
        resume_cmd = ~sus;
        @(negedge mclk);
        suspend_cmd = 1'b0;
        resume_cmd = 1'b0;
    endtask

    task automatic pwr(input logic [1:0] sel, input logic [7:0] d);
        @(negedge mclk);
        {rp_nv_wr, rp_v_wr, erp_nv_wr, erp_v_wr} = 4'h8 >> sel;
        param_wdata = d;
        @(negedge mclk);
        {rp_nv_wr, rp_v_wr, erp_nv_wr, erp_v_wr} = 4'h0;
        param_wdata = ~d;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {func_wr, prog_busy, erase_busy, suspend_cmd, resume_cmd} = 5'h00;
        {rp_nv_wr, rp_v_wr, erp_nv_wr, erp_v_wr} = 4'h0;
        {ded_reset_n, hold_reset_n} = 2'h3;
        protect_code = 4'h0;
        func_wdata = 8'h00;
        param_wdata = 8'h00;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 100 && pup_done !== 1'b1; i++) @(negedge mclk);
        // A power-up that never finishes is counted and goes straight to the report.
        if (pup_done !== 1'b1) begin
            num_errors++;
        end else begin
            run_tests();
        end
        print_verdict();
    end

    task automatic run_tests();
        check(func_rdata, 8'h00, "function reset");
        check(rp_v, fpr_pkg::RP_NV_RESET, "read param load");
        check(erp_v, fpr_pkg::ERP_NV_RESET, "ext read param load");
        pwr(2'h0, 8'ha5);
        check(rp_nv, 8'ha5, "rp nv");
        pwr(2'h1, 8'h3c);
        check(rp_v, 8'h3c, "rp v");
        check(rp_nv, 8'ha5, "rp nv kept");
        pwr(2'h2, 8'h5a);
        check(erp_v, 8'h00, "erp v kept");
        pwr(2'h3, 8'hc3);
        check(erp_v, 8'hc3, "erp v");
        check(erp_nv, 8'h5a, "erp nv");
        // Every code against every block; low address bits set to catch a wrong slice.
        for (int c = 0; c < 16; c++) begin
            protect_code = 4'(c);
            for (int b = 0; b < 64; b++) begin
                req_chk(b[0], 1'b0, 1'b0, 2'h0, {6'(b), 16'hffff}, ~prot_exp(4'(c), 6'(b)));
            end
            req_chk(1'b1, 1'b1, 1'b0, 2'h0, 22'h000000, c == 0);
        end
        // Information rows sit outside the array, so a full-array code leaves them open.
        protect_code = 4'h7;
        req_chk(1'b0, 1'b0, 1'b1, 2'h2, 22'h3fffff, 1'b1);
        protect_code = 4'h0;
        ded_reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        check({7'h00, pin_reset_n}, 8'h00, "dedicated reset");
        ded_reset_n = 1'b1;
        cmd(1'b1);
        check(func_rdata, 8'h00, "suspend while idle");
        prog_busy = 1'b1;
        cmd(1'b1);
        check(func_rdata, 8'h04, "program suspended");
        cmd(1'b0);
        check(func_rdata, 8'h00, "program resumed");
        prog_busy = 1'b0;
        erase_busy = 1'b1;
        cmd(1'b1);
        check(func_rdata, 8'h08, "erase suspended");
        cmd(1'b0);
        check(func_rdata, 8'h00, "erase resumed");
        erase_busy = 1'b0;
        fwrite(8'h10);
        check(func_rdata, 8'h10, "lock row 0");
        req_chk(1'b0, 1'b0, 1'b1, 2'h0, 22'h000000, 1'b0);
        req_chk(1'b0, 1'b0, 1'b1, 2'h1, 22'h000000, 1'b1);
        req_chk(1'b1, 1'b0, 1'b1, 2'h0, 22'h000000, 1'b1);
        fwrite(8'h00);
        check(func_rdata, 8'h10, "lock kept");
        fwrite(8'hff);
        check(func_rdata, 8'hf1, "all one-time bits");
        fwrite(8'h00);
        check(func_rdata, 8'hf1, "one-time bits kept");
        for (int r = 0; r < 4; r++) begin
            req_chk(1'b0, 1'b0, 1'b1, 2'(r), 22'h000000, 1'b0);
        end
        ded_reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        check({7'h00, pin_reset_n}, 8'h01, "dedicated pin ignored");
        hold_reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        check({7'h00, pin_reset_n}, 8'h00, "shared pin reset");
    endtask
endmodule
